// File: logic/spi_eeprom_instruction_interface.sv
// Instruction-level serial slave of a page-write EEPROM.
// Assumes cs_n, sck and si are synchronous to clk_sys and far slower.
`timescale 1ns/1ns

module spi_eeprom_instruction_interface #(
  parameter int MEM_BYTES_P = spi_eeprom_pkg::MEM_BYTES,
  parameter int PROG_CYCLES_P = spi_eeprom_pkg::PROG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  output logic busy,
  output logic write_enabled
);
  import spi_eeprom_pkg::*;

  localparam int AW = $clog2(MEM_BYTES_P);
  localparam int CW = $clog2(PROG_CYCLES_P + 1);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (MEM_BYTES_P < 256 || MEM_BYTES_P > 65536 ||
        (MEM_BYTES_P & (MEM_BYTES_P - 1)) != 0) begin : g_bad
      $error("Unsupported memory size");
    end
  endgenerate

  generate
    if (PROG_CYCLES_P < 1) begin : g_bad_prog
      $error("Programming time must be at least one cycle");
    end
  endgenerate

  generate
    if (PAGE_BYTES != (1 << PAGE_W) || FULL_ADDR_W != 16 ||
        AW > FULL_ADDR_W) begin : g_bad_geom
      $error("Page or address geometry does not fit the logic");
    end
  endgenerate

  generate
    if (STAT_BUSY_BIT < 0 || STAT_BUSY_BIT > 7 || STAT_WEL_BIT < 0 || STAT_WEL_BIT > 7 ||
        STAT_BUSY_BIT == STAT_WEL_BIT) begin : g_bad_status
      $error("Status bit positions must be distinct and inside one byte");
    end
  endgenerate

  // ----------------------------------------
  // Registered state
  // ----------------------------------------
  phase_t phase_q;
  logic cs_d_q;
  logic sck_d_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic is_write_q;
  logic [FULL_ADDR_W-1:0] addr_q;
  logic wel_q;
  logic got_byte_q;
  logic busy_q;
  logic committing_q;
  logic [CW-1:0] prog_cnt_q;
  logic [PAGE_W-1:0] commit_idx_q;
  logic [7:0] page_data_q [PAGE_BYTES];
  logic page_mask_q [PAGE_BYTES];
  logic [2:0] out_cnt_q;
  logic [7:0] tx_q;
  logic so_q;
  logic so_oe_q;

  // ----------------------------------------
  // Decoded events
  // ----------------------------------------
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] rx_byte;
  logic byte_done;
  logic out_phase;
  logic prog_start;
  logic [7:0] status_byte;
  logic [7:0] mem_rd_data;
  logic [7:0] load_byte;
  mem_wr_t mem_wr;
  logic op_done;
  logic wr_done;
  logic rd_next;
  logic [PAGE_W-1:0] page_idx;

  // ----------------------------------------
  // Line edges
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cs_d_q <= 1'b1;
      sck_d_q <= 1'b0;
    end else begin
      cs_d_q <= cs_n;
      sck_d_q <= sck;
    end
  end

  assign cs_fall = cs_d_q & ~cs_n;
  assign cs_rise = ~cs_d_q & cs_n;
  assign sck_rise = ~cs_n & ~sck_d_q & sck;
  assign sck_fall = ~cs_n & sck_d_q & ~sck;
  assign rx_byte = {shift_q[6:0], si};
  assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
  assign out_phase = (phase_q == PH_READ) || (phase_q == PH_STATUS);
  assign prog_start = cs_rise && (phase_q == PH_WRITE) && got_byte_q;
  assign op_done = byte_done && (phase_q == PH_OPCODE);
  assign wr_done = byte_done && (phase_q == PH_WRITE);
  assign rd_next = sck_fall && (phase_q == PH_READ) && (out_cnt_q == 3'h0);
  assign page_idx = addr_q[PAGE_W-1:0];

  // ----------------------------------------
  // Instruction sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      phase_q <= PH_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      is_write_q <= 1'b0;
    end else if (cs_n) begin
      phase_q <= PH_IDLE;
      bit_cnt_q <= 3'h0;
    end else if (cs_fall) begin
      phase_q <= PH_OPCODE;
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= rx_byte;
      if (bit_cnt_q == 3'h7) begin
        case (phase_q)
          PH_OPCODE: begin
            if (busy_q && rx_byte != OP_READ_STATUS) begin
              phase_q <= PH_IGNORE;
            end else begin
              case (rx_byte)
                OP_READ: begin
                  phase_q <= PH_ADDR_HI;
                  is_write_q <= 1'b0;
                end
                OP_WRITE: begin
                  if (wel_q) begin
                    phase_q <= PH_ADDR_HI;
                  end else begin
                    phase_q <= PH_IGNORE;
                  end
                  is_write_q <= 1'b1;
                end
                OP_READ_STATUS: begin
                  phase_q <= PH_STATUS;
                end
                default: begin
                  phase_q <= PH_IGNORE;
                end
              endcase
            end
          end
          PH_ADDR_HI: begin
            phase_q <= PH_ADDR_LO;
          end
          PH_ADDR_LO: begin
            if (is_write_q) begin
              phase_q <= PH_WRITE;
            end else begin
              phase_q <= PH_READ;
            end
          end
          default: begin
            phase_q <= phase_q;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Address counter
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      addr_q <= '0;
    end else if (byte_done && phase_q == PH_ADDR_HI) begin
      addr_q[15:8] <= rx_byte;
    end else if (byte_done && phase_q == PH_ADDR_LO) begin
      addr_q[7:0] <= rx_byte;
    end else if (wr_done) begin
      addr_q[PAGE_W-1:0] <= page_idx + PAGE_W'(1);
    end else if (rd_next) begin
      addr_q <= addr_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Write-enable latch
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wel_q <= WEL_RESET;
    end else if (op_done && !busy_q) begin
      if (rx_byte == OP_WRITE_ENABLE) begin
        wel_q <= 1'b1;
      end else if (rx_byte == OP_WRITE_DISABLE) begin
        wel_q <= 1'b0;
      end
    end else if (prog_start) begin
      wel_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Page buffer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      got_byte_q <= 1'b0;
    end else if (cs_rise) begin
      got_byte_q <= 1'b0;
    end else if (wr_done) begin
      got_byte_q <= 1'b1;
    end
  end

  generate
    for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_page
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          page_data_q[i] <= 8'h00;
        end else if (wr_done && page_idx == PAGE_W'(i)) begin
          page_data_q[i] <= rx_byte;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          page_mask_q[i] <= 1'b0;
        end else if (wr_done && page_idx == PAGE_W'(i)) begin
          page_mask_q[i] <= 1'b1;
        end else if (committing_q && commit_idx_q == PAGE_W'(i)) begin
          page_mask_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Self-timed programming cycle
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      committing_q <= 1'b0;
      prog_cnt_q <= '0;
      commit_idx_q <= '0;
    end else if (prog_start) begin
      busy_q <= 1'b1;
      prog_cnt_q <= CW'(PROG_CYCLES_P - 1);
      commit_idx_q <= '0;
    end else if (busy_q && !committing_q) begin
      if (prog_cnt_q == '0) begin
        committing_q <= 1'b1;
      end else begin
        prog_cnt_q <= prog_cnt_q - CW'(1);
      end
    end else if (committing_q) begin
      commit_idx_q <= commit_idx_q + PAGE_W'(1);
      if (commit_idx_q == PAGE_W'(PAGE_BYTES - 1)) begin
        committing_q <= 1'b0;
        busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Commit write port
  // ----------------------------------------
  always_comb begin
    mem_wr.en = committing_q && page_mask_q[commit_idx_q];
    mem_wr.addr = {addr_q[FULL_ADDR_W-1:PAGE_W], commit_idx_q};
    mem_wr.data = page_data_q[commit_idx_q];
  end

  // ----------------------------------------
  // Byte store
  // ----------------------------------------
  eeprom_store #(
    .DEPTH(MEM_BYTES_P),
    .AW(AW)
  ) u_store (
    .clk_sys(clk_sys),
    .wr(mem_wr),
    .raddr(addr_q[AW-1:0]),
    .rd_data(mem_rd_data)
  );

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_BUSY_BIT] = busy_q;
    status_byte[STAT_WEL_BIT] = wel_q;
  end

  assign load_byte = (out_cnt_q != 3'h0) ? tx_q :
                     (phase_q == PH_STATUS) ? status_byte : mem_rd_data;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      so_q <= 1'b0;
      tx_q <= 8'h00;
      out_cnt_q <= 3'h0;
    end else if (cs_n || !out_phase) begin
      out_cnt_q <= 3'h0;
    end else if (sck_fall) begin
      so_q <= load_byte[7];
      tx_q <= {load_byte[6:0], 1'b0};
      out_cnt_q <= out_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      so_oe_q <= 1'b0;
    end else if (cs_n || !out_phase) begin
      so_oe_q <= 1'b0;
    end else if (sck_fall) begin
      so_oe_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  assign so_out = so_q;
  assign so_oe = so_oe_q;
  assign busy = busy_q;
  assign write_enabled = wel_q;

endmodule // spi_eeprom_instruction_interface

// File: logic/spi_eeprom_pkg.sv
// Constants, states and carrier types for the serial EEPROM slave.
// Assumes a single 100 MHz system clock and a mode 0 serial host.

package spi_eeprom_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int MEM_BYTES = 16384;
  localparam int FULL_ADDR_W = 16;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;

  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;

  // ----------------------------------------
  // Status byte layout and reset values
  // ----------------------------------------
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam logic WEL_RESET = 1'b0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_PROG_NS = 5000000;
  localparam int PROG_CYCLES = T_PROG_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_OPCODE = 3'b001,
    PH_ADDR_HI = 3'b010,
    PH_ADDR_LO = 3'b011,
    PH_READ = 3'b100,
    PH_WRITE = 3'b101,
    PH_STATUS = 3'b110,
    PH_IGNORE = 3'b111
  } phase_t;

  typedef struct packed {
    logic en;
    logic [FULL_ADDR_W-1:0] addr;
    logic [7:0] data;
  } mem_wr_t;

endpackage

// File: logic/eeprom_store.sv
// Byte array backing the serial EEPROM, held in flip-flops.
// Assumes one write per cycle from the programming engine.
`timescale 1ns/1ns

module eeprom_store #(
  parameter int DEPTH = spi_eeprom_pkg::MEM_BYTES,
  parameter int AW = 14
) (
  input wire logic clk_sys,
  input wire spi_eeprom_pkg::mem_wr_t wr,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rd_data
);
  import spi_eeprom_pkg::*;

  generate
    if (AW < 1 || DEPTH != (1 << AW)) begin : g_bad
      $error("Store depth must be two to the power of its address width");
    end
  endgenerate

  logic [7:0] mem_q [DEPTH];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (wr.en) begin
      mem_q[wr.addr[AW-1:0]] <= wr.data;
    end
  end

  assign rd_data = mem_q[raddr];

endmodule // eeprom_store

// File: testbench/spi_eeprom_chk.sv
// Port-level assertions for the serial EEPROM slave.
// Assumes binding to the top module, one clock domain.
`timescale 1ns/1ns

module spi_eeprom_chk #(
  parameter int MEM_BYTES_P = 16384,
  parameter int PROG_CYCLES_P = 500000
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic busy,
  input wire logic write_enabled
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ------------------------------
  // Busy length counter
  // ------------------------------
  int unsigned busy_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn || !busy) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_q + 1;
  end

  property p_oe_cs; cs_n ##1 cs_n |=> !so_oe; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("so_oe while deselected");
  property p_oe_rise; $rose(so_oe) |-> !cs_n && !sck; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("so_oe rose badly");
  property p_so_change; so_oe && so_out != $past(so_out) |-> !sck; endproperty
  a_so_change: assert property (p_so_change) else $error("so_out moved with sck high");
  property p_wel_set; $rose(write_enabled) |-> !cs_n && !busy; endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch set badly");
  property p_wel_clr; $fell(write_enabled) |-> busy || !cs_n; endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch cleared badly");
  property p_busy_wel; $rose(busy) |-> $past(write_enabled) && !write_enabled; endproperty
  a_busy_wel: assert property (p_busy_wel) else $error("write without latch");
  property p_busy_start; $rose(busy) |-> cs_n; endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy before deselect");
  property p_busy_min; $fell(busy) |-> busy_cnt_q >= PROG_CYCLES_P; endproperty
  a_busy_min: assert property (p_busy_min) else $error("programming too short");
  property p_busy_max; busy |-> busy_cnt_q <= PROG_CYCLES_P + 80; endproperty
  a_busy_max: assert property (p_busy_max) else $error("programming too long");
endmodule // spi_eeprom_chk

bind spi_eeprom_instruction_interface spi_eeprom_chk #(
  .MEM_BYTES_P(MEM_BYTES_P),
  .PROG_CYCLES_P(PROG_CYCLES_P)
) u_chk (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .cs_n(cs_n),
  .sck(sck),
  .si(si),
  .so_out(so_out),
  .so_oe(so_oe),
  .busy(busy),
  .write_enabled(write_enabled)
);

// File: testbench/spi_host.sv
// Serial host model: select, clock and data toward the memory.
// Assumes clk_sys at 100 MHz; lines change at its falling edge.
`timescale 1ns/1ns

module spi_host (
  input wire logic clk_sys,
  input wire logic so_out,
  output logic cs_n,
  output logic sck,
  output logic si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Host opens every frame
  task automatic sel;
    cs_n = 1'b0;
    wait_n(2);
  endtask

  // Close frame, then leave si moving
  task automatic desel;
    wait_n(2);
    cs_n = 1'b1;
    si = ~si;
    wait_n(3);
  endtask

  // One byte, MSB first, 34-cycle period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      wait_n(17);
      rx[i] = so_out;
      sck = 1'b1;
      wait_n(17);
      sck = 1'b0;
    end
  endtask
endmodule // spi_host

// File: testbench/tb_spi_eeprom_instruction_interface.sv
// Self-checking bench for the serial EEPROM slave.
// Assumes spi_host.sv and the bound checker.
`timescale 1ns/1ns

module tb_spi_eeprom_instruction_interface;
  import spi_eeprom_pkg::*;
  localparam int PROG = 2000;
  logic clk_sys, resetn, cs_n, sck, si, so_out, so_oe, busy, write_enabled;
  logic [7:0] rx, st;
  int n_mismatch = 0;
  int n_tests = 0;

  spi_eeprom_instruction_interface #(.PROG_CYCLES_P(PROG)) dut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cs_n(cs_n),
    .sck(sck),
    .si(si),
    .so_out(so_out),
    .so_oe(so_oe),
    .busy(busy),
    .write_enabled(write_enabled)
  );
  spi_host host (.clk_sys(clk_sys), .so_out(so_out), .cs_n(cs_n), .sck(sck), .si(si));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic op1(input logic [7:0] op);
    host.sel();
    host.xfer(op, rx);
    host.desel();
  endtask

  task automatic opa(input logic [7:0] op, input logic [15:0] a);
    host.sel();
    host.xfer(op, rx);
    host.xfer(a[15:8], rx);
    host.xfer(a[7:0], rx);
  endtask

  task automatic status(output logic [7:0] s);
    host.sel();
    host.xfer(OP_READ_STATUS, rx);
    host.xfer(8'h00, s);
    host.desel();
  endtask

  task automatic t_latch;
    check("idle", 8'h00, {5'h00, so_oe, busy, write_enabled});
    host.xfer(OP_WRITE_ENABLE, rx);
    check("latch noise", 8'h00, {7'h00, write_enabled});
    opa(OP_READ, 16'h0000);
    host.desel();
    op1(OP_WRITE_ENABLE);
    check("latch set", 8'h01, {7'h00, write_enabled});
    status(st);
    check("status wel", 8'h02, st);
    op1(OP_WRITE_DISABLE);
    check("latch clr", 8'h00, {7'h00, write_enabled});
    opa(OP_WRITE, 16'h0010);
    host.xfer(8'h55, rx);
    host.desel();
    check("refused", 8'h00, {7'h00, busy});
  endtask

  task automatic t_page;
    op1(OP_WRITE_ENABLE);
    opa(OP_WRITE, 16'h003e);
    host.xfer(8'ha0, rx);
    host.xfer(8'ha1, rx);
    host.xfer(8'ha2, rx);
    host.desel();
    check("busy wel", 8'h02, {6'h00, busy, write_enabled});
    op1(OP_WRITE_ENABLE);
    check("wel busy", 8'h00, {7'h00, write_enabled});
    status(st);
    check("status busy", 8'h01, st);
    for (int i = 0; i < 10 && st[0] === 1'b1; i++) status(st);
    check("status done", 8'h00, st);
  endtask

  task automatic t_read;
    opa(OP_READ, 16'h003e);
    host.xfer(8'ha5, rx);
    check("rd 3e", 8'ha0, rx);
    host.xfer(8'h5a, rx);
    check("rd 3f", 8'ha1, rx);
    check("oe rd", 8'h01, {7'h00, so_oe});
    host.desel();
    check("oe off", 8'h00, {7'h00, so_oe});
    opa(OP_READ, 16'h0000);
    host.xfer(8'h00, rx);
    host.desel();
    check("rd wrap", 8'ha2, rx);
    opa(OP_READ, 16'h403e);
    host.xfer(8'h00, rx);
    host.desel();
    check("rd alias", 8'ha0, rx);
  endtask

  initial begin
    resetn = 1'b0;
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys);
    t_latch();
    t_page();
    t_read();
    summarize();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end
endmodule // tb_spi_eeprom_instruction_interface
